// ---- src/safety_ctrl_pkg.sv ----
/*
  package for the safety state and reserve control block: state and
  power-mode enumerations, reset values and timing constants.
  assumes a single 50 MHz clock domain.
*/
package safety_ctrl_pkg;

	// ------------------------------------------------------------
	// operating states of the system state machine
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_INIT,
		ST_DIAG,
		ST_SAFING,
		ST_SCRAP,
		ST_ARMING
	} sys_state_t;

	// ------------------------------------------------------------
	// power modes as seen by this block
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		PM_ACTIVE,
		PM_PASSIVE,
		PM_OFF
	} power_mode_t;

	// ------------------------------------------------------------
	// reset values and timing
	// ------------------------------------------------------------
	localparam logic RST_BOOST_HIGH_SEL = 1'b0;  // lower output voltage at power-on
	localparam logic RST_BOOST_EN       = 1'b1;  // boost runs in active mode
	localparam int   CLK_HZ             = 50_000_000;
	localparam int   ARM_TIMEOUT_US     = 100;   // arming window, plain default
	localparam int   ARM_TIMEOUT_CYC    = (ARM_TIMEOUT_US * (CLK_HZ / 1_000_000));
	localparam int   DIAG_TEST_CNT      = 3;     // hs switch, ls switch, safing fet
	localparam int   TEST_RUN_US        = 10;    // length of one diag test
	localparam int   TEST_RUN_CYC       = (TEST_RUN_US * (CLK_HZ / 1_000_000));

endpackage

// ---- src/event_sync.sv ----
/*
  event_sync: two-flop synchroniser for a bus of asynchronous levels.
  assumes inputs come from pins or analog comparators outside clk.
*/
`timescale 1ns/100ps

module event_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk,
	input  wire logic             rstLocal_n,
	input  wire logic [WIDTH-1:0] asyncIn,
	output logic      [WIDTH-1:0] syncOut
);

	// ------------------------------------------------------------
	// synchroniser stages
	// ------------------------------------------------------------
	logic [WIDTH-1:0] meta_q;  // first stage, read only by second stage

	// two flops per bit; reset value is all zero
	always_ff @(posedge clk or negedge rstLocal_n)
	begin
		if (!rstLocal_n)
		begin
			meta_q  <= '0;
			syncOut <= '0;
		end
		else
		begin
			meta_q  <= asyncIn;
			syncOut <= meta_q;
		end
	end

endmodule

// ---- src/safety_state_and_reserve_control.sv ----
/*
  safety_state_and_reserve_control: system state machine (init, diag,
  safing, scrap, arming) and energy reserve power control (boost enable
  and voltage, thermal latch, charge current, crossover switch).
  assumes host commands arrive as one-cycle pulses on clk from an spi
  decoder; analog conditions arrive asynchronously and are synchronised.
*/
`timescale 1ns/100ps

module safety_state_and_reserve_control #(
	parameter int ARM_TIMEOUT_CYC = safety_ctrl_pkg::ARM_TIMEOUT_CYC,
	parameter int TEST_RUN_CYC    = safety_ctrl_pkg::TEST_RUN_CYC
) (
	input  wire logic       clk,
	input  wire logic       rst_n,
	// reset sources
	input  wire logic       porActive,
	input  wire logic       wdResetActive,
	input  wire logic       wdFailure,
	// host command pulses, same clock
	input  wire logic       wdFeedOk,
	input  wire logic       cmdSafing,
	input  wire logic       cmdScrap,
	input  wire logic       cmdArmReq,
	input  wire logic       cmdSleep,
	input  wire logic       cmdChargeOn,
	input  wire logic       cmdChargeOff,
	input  wire logic [1:0] cmdTestSel,
	input  wire logic       cmdTestStart,
	input  wire logic       cfgWrite,
	input  wire logic       faultStatusRead,
	input  wire logic       aclRefresh,
	// system control and config bits
	input  wire logic       boostEnableCfg,
	input  wire logic       boostHighSelCfg,
	input  wire logic       keepBoostInPassive,
	// asynchronous analog conditions
	input  wire logic       wakeIn,
	input  wire logic       supplyLow,
	input  wire logic       batteryLost,
	input  wire logic       boostUnderVolt,
	input  wire logic       boostOverTemp,
	input  wire logic       groundLost,
	input  wire logic       supplyAboveReserve,
	// outputs
	output logic [2:0]      sysState,
	output logic            stateMachineReset,
	output logic            armOut,
	output logic            safingActive,
	output logic            sensorMonitorEn,
	output logic            cfgAccepted,
	output logic [2:0]      testActive,
	output logic            passiveMode,
	output logic            boostEnable,
	output logic            boostHighSel,
	output logic            boostNotOkFlag,
	output logic            boostOvertempFlag,
	output logic            chargeEnable,
	output logic            crossoverSwitchOn,
	output logic            crossoverActiveOut
);

	// ------------------------------------------------------------
	// reset release and input synchronisers
	// ------------------------------------------------------------
	logic        rstMeta_q;   // first reset flop
	logic        rstLocal_n;  // released reset used by the rest
	logic [6:0]  rawAsync;    // packed analog conditions
	logic [6:0]  syncCond;    // synchronised copies
	logic        wakeS;
	logic        supplyLowS;
	logic        batLostS;
	logic        bstUvS;
	logic        bstOtS;
	logic        gndLostS;
	logic        aboveResS;

	// reset asserts at once, releases after two edges
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rstMeta_q  <= 1'b0;
			rstLocal_n <= 1'b0;
		end
		else
		begin
			rstMeta_q  <= 1'b1;
			rstLocal_n <= rstMeta_q;
		end
	end

	assign rawAsync = {wakeIn, supplyLow, batteryLost, boostUnderVolt,
		boostOverTemp, groundLost, supplyAboveReserve};

	event_sync #(
		.WIDTH(7)
	) condSync (
		.clk       (clk),
		.rstLocal_n(rstLocal_n),
		.asyncIn   (rawAsync),
		.syncOut   (syncCond)
	);

	assign {wakeS, supplyLowS, batLostS, bstUvS, bstOtS, gndLostS, aboveResS} = syncCond;

	// ------------------------------------------------------------
	// state machine reset
	// ------------------------------------------------------------
	// combine reset sources
	// the registered copy is the stateMachineReset output further down
	wire ssmResetD = porActive | wdResetActive | wdFailure;

	// ------------------------------------------------------------
	// system state machine
	// ------------------------------------------------------------
	safety_ctrl_pkg::sys_state_t state_q, state_d;
	logic [31:0] armCnt_q;     // arming window counter
	wire         armExpired = (armCnt_q == 32'h0000_0001);

	// next-state decode; commands off-state simply fall through
	always_comb
	begin
		state_d = state_q;
		unique case (state_q)
			safety_ctrl_pkg::ST_INIT:
				if (wdFeedOk)
					state_d = safety_ctrl_pkg::ST_DIAG;
			// diag waits for safing or scrap; safing wins a tie
			safety_ctrl_pkg::ST_DIAG:
				if (cmdSafing)
					state_d = safety_ctrl_pkg::ST_SAFING;  // enter safing
				else if (cmdScrap)
					state_d = safety_ctrl_pkg::ST_SCRAP;   // enter scrap
			// safing has no exit besides reset
			safety_ctrl_pkg::ST_SAFING:
				state_d = safety_ctrl_pkg::ST_SAFING;
			safety_ctrl_pkg::ST_SCRAP:
				if (cmdArmReq)
					state_d = safety_ctrl_pkg::ST_ARMING;
			safety_ctrl_pkg::ST_ARMING:
				if (armExpired && !aclRefresh)
					state_d = safety_ctrl_pkg::ST_SCRAP;
			default:
				state_d = safety_ctrl_pkg::ST_INIT;
		endcase
	end

	// stray safing/scrap commands need no branch: only diag reads them
	// reset drops the machine into init
	always_ff @(posedge clk or negedge rstLocal_n)
	begin
		if (!rstLocal_n)
			state_q <= safety_ctrl_pkg::ST_INIT;
		else if (ssmResetD)
			state_q <= safety_ctrl_pkg::ST_INIT;
		else
			state_q <= state_d;
	end

	// arming window reloads on entry and on each good acl refresh
	wire armLoad = (state_d == safety_ctrl_pkg::ST_ARMING)
		&& ((state_q != safety_ctrl_pkg::ST_ARMING) || aclRefresh);

	always_ff @(posedge clk or negedge rstLocal_n)
	begin
		if (!rstLocal_n)
			armCnt_q <= 32'h0000_0000;
		else if (armLoad)
			armCnt_q <= 32'(ARM_TIMEOUT_CYC);
		else if (armCnt_q != 32'h0000_0000)
			armCnt_q <= armCnt_q - 32'h0000_0001;
	end

	// ------------------------------------------------------------
	// diagnostic tests, one at a time
	// ------------------------------------------------------------
	logic [2:0]  test_q;     // one-hot running test
	logic [31:0] testCnt_q;  // remaining run time
	wire inDiagD = (state_d == safety_ctrl_pkg::ST_DIAG) && !ssmResetD;
	// start only in diag; only when idle, one index
	wire testGo = cmdTestStart && inDiagD && (test_q == 3'b000)
		&& (cmdTestSel < 2'(safety_ctrl_pkg::DIAG_TEST_CNT));

	always_ff @(posedge clk or negedge rstLocal_n)
	begin
		if (!rstLocal_n)
		begin
			test_q    <= 3'b000;
			testCnt_q <= 32'h0000_0000;
		end
		else if (!inDiagD)
		begin
			// leaving diag aborts any test
			test_q    <= 3'b000;
			testCnt_q <= 32'h0000_0000;
		end
		else if (testGo)
		begin
			test_q    <= 3'b001 << cmdTestSel;
			testCnt_q <= 32'(TEST_RUN_CYC);
		end
		else if (testCnt_q == 32'h0000_0001)
		begin
			test_q    <= 3'b000;
			testCnt_q <= 32'h0000_0000;
		end
		else if (testCnt_q != 32'h0000_0000)
			testCnt_q <= testCnt_q - 32'h0000_0001;
	end

	// ------------------------------------------------------------
	// power mode tracking
	// ------------------------------------------------------------
	safety_ctrl_pkg::power_mode_t pm_q;
	// sleep after wake released; supply drop alone
	wire goPassive = (pm_q == safety_ctrl_pkg::PM_ACTIVE)
		&& ((cmdSleep && !wakeS) || supplyLowS);

	always_ff @(posedge clk or negedge rstLocal_n)
	begin
		if (!rstLocal_n)
			pm_q <= safety_ctrl_pkg::PM_ACTIVE;
		else if (goPassive)
			pm_q <= safety_ctrl_pkg::PM_PASSIVE;
	end

	wire passiveD = goPassive || (pm_q == safety_ctrl_pkg::PM_PASSIVE);

	// ------------------------------------------------------------
	// boost converter control and fault flags
	// ------------------------------------------------------------
	logic otLatch_q;     // thermal off-latch
	logic overtemp_q;    // fault status copy
	logic charge_q;      // host charge request

	// latch on fault; read clears, but a new fault wins
	// fault status read clears latched cause
	always_ff @(posedge clk or negedge rstLocal_n)
	begin
		if (!rstLocal_n)
		begin
			otLatch_q  <= 1'b0;
			overtemp_q <= 1'b0;
		end
		else if (bstOtS)
		begin
			otLatch_q  <= 1'b1;
			overtemp_q <= 1'b1;
		end
		else if (faultStatusRead)
		begin
			otLatch_q  <= 1'b0;
			overtemp_q <= 1'b0;
		end
	end

	// ground loss is a plain gate, no memory
	// shutdown or battery loss kills boost
	// passive kills boost unless keep bit set
	wire boostOnD = boostEnableCfg && !otLatch_q && !bstOtS && !gndLostS && !batLostS
		&& (!passiveD || keepBoostInPassive);

	// charge generator forced off outside active
	always_ff @(posedge clk or negedge rstLocal_n)
	begin
		if (!rstLocal_n)
			charge_q <= 1'b0;
		else if (passiveD)
			charge_q <= 1'b0;
		else if (cmdChargeOn)
			charge_q <= 1'b1;
		else if (cmdChargeOff)
			charge_q <= 1'b0;
	end

	// crossover on in passive until supply beats reserve
	wire xoverD = passiveD && !aboveResS;

	// ------------------------------------------------------------
	// output registers
	// ------------------------------------------------------------
	wire inSafingD = (state_d == safety_ctrl_pkg::ST_SAFING) && !ssmResetD;
	wire inArmingD = (state_d == safety_ctrl_pkg::ST_ARMING) && !ssmResetD;
	wire inInitD   = ssmResetD || (state_d == safety_ctrl_pkg::ST_INIT);

	always_ff @(posedge clk or negedge rstLocal_n)
	begin
		if (!rstLocal_n)
		begin
			sysState           <= 3'h0;
			stateMachineReset  <= 1'b1;
			armOut             <= 1'b0;
			safingActive       <= 1'b0;
			sensorMonitorEn    <= 1'b0;
			cfgAccepted        <= 1'b0;
			testActive         <= 3'b000;
			passiveMode        <= 1'b0;
			boostEnable        <= 1'b0;
			boostHighSel       <= safety_ctrl_pkg::RST_BOOST_HIGH_SEL;
			boostNotOkFlag     <= 1'b0;
			boostOvertempFlag  <= 1'b0;
			chargeEnable       <= 1'b0;
			crossoverSwitchOn  <= 1'b0;
			crossoverActiveOut <= 1'b0;
		end
		else
		begin
			sysState           <= ssmResetD ? 3'h0 : state_d;
			stateMachineReset  <= ssmResetD;
			// safing arms; arming holds arm output
			armOut             <= inSafingD || inArmingD;
			safingActive       <= inSafingD;
			// scrap and arming disable sensor monitoring
			sensorMonitorEn    <= inSafingD;
			cfgAccepted        <= cfgWrite && (inInitD || inDiagD);
			testActive         <= testGo ? (3'b001 << cmdTestSel) : test_q;
			passiveMode        <= passiveD;
			boostEnable        <= boostOnD;
			boostHighSel       <= boostHighSelCfg;
			boostNotOkFlag     <= bstUvS;
			boostOvertempFlag  <= overtemp_q;
			chargeEnable       <= charge_q && !passiveD;
			crossoverSwitchOn  <= xoverD;
			crossoverActiveOut <= passiveD;
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	a_safing_sticky: assert property (@(posedge clk) disable iff (!rstLocal_n)
		(state_q == safety_ctrl_pkg::ST_SAFING && !ssmResetD)
		|=> (state_q == safety_ctrl_pkg::ST_SAFING))
		else $error("safing left without reset");

	a_scrap_exit: assert property (@(posedge clk) disable iff (!rstLocal_n)
		(state_q == safety_ctrl_pkg::ST_SCRAP && !ssmResetD)
		|=> (state_q inside {safety_ctrl_pkg::ST_SCRAP, safety_ctrl_pkg::ST_ARMING}))
		else $error("scrap went somewhere other than arming");

	a_reset_init: assert property (@(posedge clk) disable iff (!rstLocal_n)
		ssmResetD |=> (state_q == safety_ctrl_pkg::ST_INIT) && stateMachineReset)
		else $error("reset did not return to init");

	a_init_feed: assert property (@(posedge clk) disable iff (!rstLocal_n)
		(state_q == safety_ctrl_pkg::ST_INIT && wdFeedOk && !ssmResetD)
		|=> (state_q == safety_ctrl_pkg::ST_DIAG))
		else $error("feed did not leave init");

	a_stray_cmd: assert property (@(posedge clk) disable iff (!rstLocal_n)
		(state_q == safety_ctrl_pkg::ST_INIT && !wdFeedOk && (cmdSafing || cmdScrap))
		|=> (state_q == safety_ctrl_pkg::ST_INIT))
		else $error("state command outside diag acted");

	a_arm_out: assert property (@(posedge clk) disable iff (!rstLocal_n)
		(state_q == safety_ctrl_pkg::ST_ARMING) |-> armOut)
		else $error("arm output low in arming");

	a_test_single: assert property (@(posedge clk) disable iff (!rstLocal_n)
		$onehot0(test_q) && (test_q == 3'b000 || inDiagD || $past(inDiagD)))
		else $error("tests overlap or run outside diag");

	a_ot_latch: assert property (@(posedge clk) disable iff (!rstLocal_n)
		(otLatch_q && !faultStatusRead) |=> (otLatch_q && !boostEnable))
		else $error("boost on while thermal latch set");

	a_charge_off: assert property (@(posedge clk) disable iff (!rstLocal_n)
		passiveMode |-> (!chargeEnable && !charge_q))
		else $error("charge current on outside active");

	a_xover_pin: assert property (@(posedge clk) disable iff (!rstLocal_n)
		goPassive |=> crossoverActiveOut [*2])
		else $error("crossover pin not driven in passive");

endmodule

// ---- tb/host_model.sv ----
/*
  host_model: microcontroller side of the block, sending one-cycle
  command pulses as an spi decoder would hand them over.
  assumes one clock shared with the block, pulses launched after the edge.
*/
`timescale 1ns/100ps

module host_model (
	input  wire logic        clk,
	output logic      [10:0] pulse,
	output logic      [1:0]  testSel
);

	// ------------------------------------------------------------
	// idle state
	// ------------------------------------------------------------
	// all strobes low from time zero
	initial
	begin
		pulse   = 11'h000;
		testSel = 2'h0;
	end

	// ------------------------------------------------------------
	// command frame
	// ------------------------------------------------------------
	// one strobe per frame, feed is bit zero
	// an idle cycle first, so no strobe is lowered and raised at once
	task automatic send(input int op, input logic [1:0] sel);
		@(posedge clk);
		#1;
		testSel = sel;  // held after the frame, as a decoder would
		pulse   = 11'h001 << op;
		@(posedge clk);
		#1;
		pulse   = 11'h000;
	endtask

endmodule

// ---- tb/safety_state_and_reserve_control_tb.sv ----
/*
  self-checking bench for the safety state and reserve control block.
  assumes the block takes pulses on the rising edge and answers a cycle
  later, and analog levels three cycles later.
*/
`timescale 1ns/100ps

module safety_state_and_reserve_control_tb;

	// ------------------------------------------------------------
	// signals
	// ------------------------------------------------------------
	localparam int ARM_T = 20;  // shortened arming window
	localparam int TST_T = 10;  // shortened test run
	localparam int FEED = 0, SAF = 1, SCR = 2, ARM = 3, SLP = 4, CON = 5;
	localparam int COFF = 6, TST = 7, CFG = 8, FRD = 9, ADDITIONAL_COMM_LINE = 10;
	logic        clk = 1'b0, rst_n = 1'b0;
	logic        porActive = 0, wdResetActive = 0, wdFailure = 0;
	logic        boostEnableCfg = 1, boostHighSelCfg = 0, keepBoostInPassive = 0;
	logic        wakeIn = 0, supplyLow = 0, batteryLost = 0, boostUnderVolt = 0;
	logic        boostOverTemp = 0, groundLost = 0, supplyAboveReserve = 0;
	logic [10:0] pulse;
	logic [1:0]  testSel;
	logic [2:0]  sysState, testActive;
	logic        stateMachineReset, armOut, safingActive, sensorMonitorEn;
	logic        cfgAccepted, passiveMode, boostEnable, boostHighSel;
	logic        boostNotOkFlag, boostOvertempFlag, chargeEnable;
	logic        crossoverSwitchOn, crossoverActiveOut;
	int          n_errors = 0, cmp_count = 0;

	// 50 MHz
	always #10 clk = ~clk;

	host_model u_host_model (.clk(clk), .pulse(pulse), .testSel(testSel));

	safety_state_and_reserve_control #(.ARM_TIMEOUT_CYC(ARM_T), .TEST_RUN_CYC(TST_T))
	u_safety_state_and_reserve_control (
		.clk(clk), .rst_n(rst_n), .porActive(porActive),
		.wdResetActive(wdResetActive), .wdFailure(wdFailure),
		.wdFeedOk(pulse[0]), .cmdSafing(pulse[1]), .cmdScrap(pulse[2]),
		.cmdArmReq(pulse[3]), .cmdSleep(pulse[4]), .cmdChargeOn(pulse[5]),
		.cmdChargeOff(pulse[6]), .cmdTestSel(testSel), .cmdTestStart(pulse[7]),
		.cfgWrite(pulse[8]), .faultStatusRead(pulse[9]), .aclRefresh(pulse[10]),
		.boostEnableCfg(boostEnableCfg), .boostHighSelCfg(boostHighSelCfg),
		.keepBoostInPassive(keepBoostInPassive), .wakeIn(wakeIn),
		.supplyLow(supplyLow), .batteryLost(batteryLost),
		.boostUnderVolt(boostUnderVolt), .boostOverTemp(boostOverTemp),
		.groundLost(groundLost), .supplyAboveReserve(supplyAboveReserve),
		.sysState(sysState), .stateMachineReset(stateMachineReset),
		.armOut(armOut), .safingActive(safingActive),
		.sensorMonitorEn(sensorMonitorEn), .cfgAccepted(cfgAccepted),
		.testActive(testActive), .passiveMode(passiveMode),
		.boostEnable(boostEnable), .boostHighSel(boostHighSel),
		.boostNotOkFlag(boostNotOkFlag), .boostOvertempFlag(boostOvertempFlag),
		.chargeEnable(chargeEnable), .crossoverSwitchOn(crossoverSwitchOn),
		.crossoverActiveOut(crossoverActiveOut)
	);

	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	// land just after an edge so outputs have settled
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// four-state compare, so an unknown never matches
	task automatic chk(input string nm, input logic [2:0] e, input logic [2:0] g);
		cmp_count++;
		if (g !== e)
		begin
			$display("BAD %s expected %h seen %h", nm, e, g);
			n_errors++;
		end
	endtask

	task automatic send(input int op, input logic [1:0] sel = 2'h0);
		u_host_model.send(op, sel);
	endtask

	task automatic stop_test();
		if (n_errors == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// async reset held four cycles, then three edges of settling
	task automatic do_reset();
		rst_n = 1'b0;
		{supplyLow, supplyAboveReserve, wakeIn} = 3'h0;
		cyc(4);
		rst_n = 1'b1;
		cyc(3);
	endtask

	// w: 0 power-on, 1 watchdog reset, 2 watchdog failure
	task automatic src_reset(input int w);
		{wdFailure, wdResetActive, porActive} = 3'h1 << w;
		cyc(3);
		chk("smReset", 1, stateMachineReset);
		chk("stateRst", safety_ctrl_pkg::ST_INIT, sysState);
		{wdFailure, wdResetActive, porActive} = 3'h0;
		cyc(3);
		chk("smRelease", 0, stateMachineReset);
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_init();
		chk("stInit", safety_ctrl_pkg::ST_INIT, sysState);
		chk("hiSelRst", 0, boostHighSel);
		send(CFG);
		chk("cfgInit", 1, cfgAccepted);
		send(SAF);
		send(SCR);
		chk("ignInit", safety_ctrl_pkg::ST_INIT, sysState);
		send(TST, 2'h0);
		chk("tstInit", 0, testActive);
		send(FEED);
		chk("feed", safety_ctrl_pkg::ST_DIAG, sysState);
	endtask

	task automatic t_diag();
		send(CFG);
		chk("cfgDiag", 1, cfgAccepted);
		for (int s = 0; s < 3; s++)
		begin
			send(TST, 2'(s));
			chk("tstRun", 3'h1 << s, testActive);
			send(TST, 2'((s + 1) % 3));
			chk("tstOverlap", 3'h1 << s, testActive);
			cyc(TST_T + 2);
			chk("tstDone", 0, testActive);
		end
		send(TST, 2'h3);
		chk("tstSel3", 0, testActive);
		cyc(5);
		chk("diagHold", safety_ctrl_pkg::ST_DIAG, sysState);
	endtask

	task automatic t_safing();
		send(SAF);
		chk("stSafing", safety_ctrl_pkg::ST_SAFING, sysState);
		chk("armSaf", 1, {armOut, safingActive, sensorMonitorEn} == 3'h7);
		send(SCR);
		send(FEED);
		send(TST, 2'h1);
		chk("safStay", safety_ctrl_pkg::ST_SAFING, sysState);
		chk("tstSaf", 0, testActive);
		send(CFG);
		chk("cfgSaf", 0, cfgAccepted);
		src_reset(0);
	endtask

	task automatic t_scrap();
		send(FEED);
		send(SCR);
		chk("stScrap", safety_ctrl_pkg::ST_SCRAP, sysState);
		chk("scrapOff", 0, safingActive | sensorMonitorEn);
		send(SAF);
		chk("scrapStay", safety_ctrl_pkg::ST_SCRAP, sysState);
		send(ARM);
		chk("stArming", safety_ctrl_pkg::ST_ARMING, sysState);
		chk("armOut", 1, armOut);
		cyc(ARM_T - 6);
		send(ADDITIONAL_COMM_LINE);
		cyc(8);
		chk("aclKeep", safety_ctrl_pkg::ST_ARMING, sysState);
		cyc(ARM_T + 2);
		chk("armExpire", safety_ctrl_pkg::ST_SCRAP, sysState);
		chk("armDrop", 0, armOut);
		src_reset(2);
	endtask

	task automatic t_boost();
		chk("bstOn", 1, boostEnable);
		boostHighSelCfg = 1'b1;
		cyc(2);
		chk("hiSel", 1, boostHighSel);
		boostEnableCfg = 1'b0;
		cyc(2);
		chk("bstCfgOff", 0, boostEnable);
		boostEnableCfg = 1'b1;
		boostUnderVolt = 1'b1;
		cyc(3);
		chk("notOk", 1, boostNotOkFlag);
		boostUnderVolt = 1'b0;
		boostOverTemp  = 1'b1;
		// sync, latch, then the flag copy: four edges
		cyc(4);
		chk("otFlag", 1, boostOvertempFlag);
		boostOverTemp = 1'b0;
		cyc(4);
		chk("otLatch", 0, boostEnable);
		send(FRD);
		cyc(1);
		chk("otClear", 0, boostOvertempFlag);
		chk("otResume", 1, boostEnable);
		groundLost = 1'b1;
		cyc(3);
		chk("gndOff", 0, boostEnable);
		groundLost  = 1'b0;
		cyc(3);
		chk("gndBack", 1, boostEnable);
		batteryLost = 1'b1;
		cyc(3);
		chk("batOff", 0, boostEnable);
		batteryLost = 1'b0;
		// charge output trails the request register by one edge
		send(CON);
		cyc(1);
		chk("chgOn", 1, chargeEnable);
		send(COFF);
		cyc(1);
		chk("chgOff", 0, chargeEnable);
		send(CON);
	endtask

	// keep: boost held in passive; viaSupply: supply drop, no command
	task automatic t_passive(input logic keep, input logic viaSupply);
		keepBoostInPassive = keep;
		wakeIn = 1'b1;
		cyc(3);
		send(SLP);
		chk("sleepWake", 0, passiveMode);
		wakeIn = 1'b0;
		cyc(3);
		if (viaSupply)
		begin
			supplyLow = 1'b1;
			cyc(3);
		end
		else
			send(SLP);
		chk("passive", 1, passiveMode);
		chk("covrPin", 1, crossoverActiveOut);
		chk("xSwitch", 1, crossoverSwitchOn);
		chk("bstPass", keep, boostEnable);
		chk("chgPass", 0, chargeEnable);
		send(CON);
		chk("chgRefuse", 0, chargeEnable);
		supplyAboveReserve = 1'b1;
		cyc(3);
		chk("xSwOff", 0, crossoverSwitchOn);
	endtask

	// ------------------------------------------------------------
	// main sequence and hang guard
	// ------------------------------------------------------------
	initial
	begin
		do_reset();
		t_init();
		t_diag();
		t_safing();
		t_scrap();
		src_reset(1);
		t_boost();
		t_passive(1'b0, 1'b0);
		do_reset();
		t_passive(1'b1, 1'b1);
		stop_test();
	end

	// the run needs far less; reaching this counts as a mismatch
	initial
	begin
		#1000000;
		n_errors++;
		stop_test();
	end

endmodule
